// ### dmacb_defines.svh
// register offsets, field positions and reset values of the channel b control block
`ifndef DMACB_DEFINES_SVH
`define DMACB_DEFINES_SVH

// ****************************************************************
// register byte offsets
// ****************************************************************
`define DMACB_CTRL_OFS   8'h00
`define DMACB_ADDR_OFS   8'h04
`define DMACB_STAT_OFS   8'h08

// ****************************************************************
// control register fields
// ****************************************************************
`define DMACB_SRC_LSB    0
`define DMACB_SRC_MSB    2
`define DMACB_TMS_BIT    3
`define DMACB_STEP_EN    4
`define DMACB_STEP_DIR   5
`define DMACB_BLK_BIT    6
`define DMACB_SIZE_BIT   7
`define DMACB_ENA_BIT    8
`define DMACB_CTRL_W     9
`define DMACB_CTRL_RST   9'h000

// ****************************************************************
// status register fields
// ****************************************************************
`define DMACB_ST_PEND    0
`define DMACB_ST_REQ     1
`define DMACB_ST_ILL     2
`define DMACB_ST_EXTLOW  3

// ****************************************************************
// address step sizes
// ****************************************************************
`define DMACB_STEP_BYTE  2'h1
`define DMACB_STEP_WORD  2'h2

`endif

// ### dmacb_pkg.sv
// types shared by the channel b control block
package dmacb_pkg;

  // activation source selected by code and mode
  typedef enum logic [2:0] {
    SRC_NONE,
    SRC_AUTO_BURST,
    SRC_AUTO_STEAL,
    SRC_TIMER,
    SRC_EXT_EDGE,
    SRC_EXT_LEVEL
  } dmacb_src_t;

endpackage

// ### dmacb_pin_sync.sv
// two-stage synchroniser with falling edge detect for the external request pin
`timescale 1ns/1ps

module dmacb_pin_sync (
  input  wire logic mclk,
  input  wire logic rst,
  input  wire logic pin_n,
  output logic      pin_low,
  output logic      pin_fall
);

  logic meta_ff;
  logic sync_ff;
  logic prev_ff;

  // pin idles high, so reset to the idle level to avoid a false edge
  always_ff @(posedge mclk) begin
    if (rst) begin
      meta_ff <= 1'b1;
      sync_ff <= 1'b1;
      prev_ff <= 1'b1;
    end else begin
      meta_ff <= pin_n;
      sync_ff <= meta_ff;
      prev_ff <= sync_ff;
    end
  end

  assign pin_low  = ~sync_ff;
  assign pin_fall = prev_ff & ~sync_ff;

endmodule

// ### dmacb_chan.sv
// channel b activation source decode, request logic and destination address stepping
`timescale 1ns/1ps
`include "dmacb_defines.svh"

// Operation
// - code 000: burst auto-request, block: timer 0
// - code 010: cycle-steal auto-request, block: timer 2
// - codes 001/011: illegal normal, block: timers 1/3
// - code 110: request pin falling edge, both modes
// - code 111: request pin low level, normal only
// - block mode, select 0: destination is block
// - block mode, select 1: source is block
// - step disabled holds address; bit 5 sets direction
// - increment word size adds two per transfer
// - decrement byte size subtracts one per transfer
module dmacb_chan #(
  parameter int AW = 24
) (
  input  wire logic          mclk,
  input  wire logic          rst,
  input  wire logic          wb_cyc_i,
  input  wire logic          wb_stb_i,
  input  wire logic          wb_we_i,
  input  wire logic [7:0]    wb_adr_i,
  input  wire logic [3:0]    wb_sel_i,
  input  wire logic [31:0]   wb_dat_i,
  output logic      [31:0]   wb_dat_o,
  output logic               wb_ack_o,
  input  wire logic [3:0]    timer_match_a,
  input  wire logic          ext_transfer_request_n,
  input  wire logic          xfer_ack,
  input  wire logic          xfer_done,
  output logic               xfer_req,
  output logic               burst_mode,
  output logic               cycle_steal,
  output logic               src_is_block,
  output logic               cfg_illegal,
  output logic      [AW-1:0] dest_address_reg
);

  // ****************************************************************
  // wishbone slave
  // ****************************************************************
  logic                    ack_ff;
  logic [31:0]             rdat_ff;
  logic [`DMACB_CTRL_W-1:0] ctrl_ff;
  logic [AW-1:0]           addr_ff;
  logic                    pend_ff;

  wire bus_req  = wb_cyc_i & wb_stb_i & ~ack_ff;
  wire bus_wr   = bus_req & wb_we_i;
  wire hit_ctrl = (wb_adr_i == `DMACB_CTRL_OFS);
  wire hit_addr = (wb_adr_i == `DMACB_ADDR_OFS);
  wire hit_stat = (wb_adr_i == `DMACB_STAT_OFS);
  wire wr_ctrl  = bus_wr & hit_ctrl;
  wire wr_addr  = bus_wr & hit_addr;

  // ****************************************************************
  // control fields
  // ****************************************************************
  wire [2:0] act_src_sel         = ctrl_ff[`DMACB_SRC_MSB:`DMACB_SRC_LSB];
  wire       act_src_sel_b0      = act_src_sel[0];
  wire       act_src_sel_b1      = act_src_sel[1];
  wire       act_src_sel_b2      = act_src_sel[2];
  wire       xfer_mode_sel       = ctrl_ff[`DMACB_TMS_BIT];
  wire       dest_step_enable    = ctrl_ff[`DMACB_STEP_EN];
  wire       dest_step_direction = ctrl_ff[`DMACB_STEP_DIR];
  wire       block_mode          = ctrl_ff[`DMACB_BLK_BIT];
  wire       transfer_size_select = ctrl_ff[`DMACB_SIZE_BIT];
  wire       chan_enable         = ctrl_ff[`DMACB_ENA_BIT];

  // ****************************************************************
  // byte-lane merge of writes
  // ****************************************************************
  wire [`DMACB_CTRL_W-1:0] ctrl_merge;
  wire [AW-1:0]            addr_merge;
  genvar gi;
  generate
    for (gi = 0; gi < `DMACB_CTRL_W; gi++) begin : g_ctrl
      assign ctrl_merge[gi] = wb_sel_i[gi/8] ? wb_dat_i[gi] : ctrl_ff[gi];
    end
    for (gi = 0; gi < AW; gi++) begin : g_addr
      assign addr_merge[gi] = wb_sel_i[gi/8] ? wb_dat_i[gi] : addr_ff[gi];
    end
  endgenerate

  // ****************************************************************
  // activation source decode
  // ****************************************************************
  dmacb_pkg::dmacb_src_t src_kind;

  always_comb begin
    src_kind = dmacb_pkg::SRC_NONE;
    if (!block_mode) begin
      unique case ({act_src_sel_b2, act_src_sel_b1, act_src_sel_b0})
        3'h0: src_kind = dmacb_pkg::SRC_AUTO_BURST;
        3'h2: src_kind = dmacb_pkg::SRC_AUTO_STEAL;
        3'h6: src_kind = dmacb_pkg::SRC_EXT_EDGE;
        3'h7: src_kind = dmacb_pkg::SRC_EXT_LEVEL;
        default: src_kind = dmacb_pkg::SRC_NONE;
      endcase
    end else begin
      unique case ({act_src_sel_b2, act_src_sel_b1, act_src_sel_b0})
        3'h0, 3'h1, 3'h2, 3'h3: src_kind = dmacb_pkg::SRC_TIMER;
        3'h6: src_kind = dmacb_pkg::SRC_EXT_EDGE;
        default: src_kind = dmacb_pkg::SRC_NONE;
      endcase
    end
  end

  // ****************************************************************
  // request generation
  // ****************************************************************
  logic ext_low;
  logic ext_fall;

  dmacb_pin_sync u_pin_sync (
    .mclk     (mclk),
    .rst      (rst),
    .pin_n    (ext_transfer_request_n),
    .pin_low  (ext_low),
    .pin_fall (ext_fall)
  );

  // timer channel index is the low two code bits in block mode
  wire timer_hit = timer_match_a[act_src_sel[1:0]];
  wire is_auto   = (src_kind == dmacb_pkg::SRC_AUTO_BURST) | (src_kind == dmacb_pkg::SRC_AUTO_STEAL);
  wire pend_set  = chan_enable & (((src_kind == dmacb_pkg::SRC_TIMER) & timer_hit) |
                                  ((src_kind == dmacb_pkg::SRC_EXT_EDGE) & ext_fall));
  wire lvl_req   = (src_kind == dmacb_pkg::SRC_EXT_LEVEL) & ext_low;
  // an event in the ack cycle is kept; a ctrl write drops even a same-cycle event,
  // since it was decoded under the old setting and must not leak into the new one
  wire nxt_pend  = ~wr_ctrl & (pend_set | (pend_ff & ~xfer_ack));

  assign xfer_req     = chan_enable & (is_auto | pend_ff | lvl_req);
  assign burst_mode   = (src_kind == dmacb_pkg::SRC_AUTO_BURST);
  assign cycle_steal  = (src_kind == dmacb_pkg::SRC_AUTO_STEAL);
  assign src_is_block = block_mode & xfer_mode_sel;
  assign cfg_illegal  = (src_kind == dmacb_pkg::SRC_NONE);

  // ****************************************************************
  // destination address stepping
  // ****************************************************************
  wire [1:0]    step_sz  = transfer_size_select ? `DMACB_STEP_WORD : `DMACB_STEP_BYTE;
  wire [AW-1:0] step_ext = AW'(step_sz);
  wire [AW-1:0] addr_inc = AW'(addr_ff + step_ext);
  wire [AW-1:0] addr_dec = AW'(addr_ff - step_ext);
  wire [AW-1:0] addr_stp = dest_step_direction ? addr_dec : addr_inc;
  // software write takes precedence over a step in the same cycle
  wire [AW-1:0] nxt_addr = wr_addr ? addr_merge :
                           (xfer_done & dest_step_enable) ? addr_stp : addr_ff;

  assign dest_address_reg = addr_ff;

  // ****************************************************************
  // read mux and registers
  // ****************************************************************
  wire [31:0] stat_word = {28'h0000000, ext_low, cfg_illegal, xfer_req, pend_ff};
  wire [31:0] nxt_rdat  = hit_ctrl ? {{(32-`DMACB_CTRL_W){1'b0}}, ctrl_ff} :
                          hit_addr ? {{(32-AW){1'b0}}, addr_ff} :
                          hit_stat ? stat_word : 32'h00000000;

  always_ff @(posedge mclk) begin
    if (rst) begin
      ack_ff  <= 1'b0;
      rdat_ff <= 32'h00000000;
      ctrl_ff <= `DMACB_CTRL_RST;
      addr_ff <= '0;
      pend_ff <= 1'b0;
    end else begin
      ack_ff  <= bus_req;
      rdat_ff <= bus_req ? nxt_rdat : rdat_ff;
      ctrl_ff <= wr_ctrl ? ctrl_merge : ctrl_ff;
      addr_ff <= nxt_addr;
      pend_ff <= nxt_pend;
    end
  end

  assign wb_ack_o = ack_ff;
  assign wb_dat_o = rdat_ff;

  // ****************************************************************
  // assertions
  // ****************************************************************
  property p_burst_auto;
    @(posedge mclk) disable iff (rst)
      (chan_enable && !block_mode && act_src_sel == 3'h0) |-> (xfer_req && burst_mode && !cycle_steal);
  endproperty
  a_burst_auto: assert property (p_burst_auto) else $error("code 000 normal not burst auto");

  property p_steal_auto;
    @(posedge mclk) disable iff (rst)
      (chan_enable && !block_mode && act_src_sel == 3'h2) |-> (xfer_req && cycle_steal && !burst_mode);
  endproperty
  a_steal_auto: assert property (p_steal_auto) else $error("code 010 normal not cycle steal");

  property p_timer_sel;
    @(posedge mclk) disable iff (rst)
      (chan_enable && block_mode && !act_src_sel[2] && timer_match_a[act_src_sel[1:0]] && !wr_ctrl)
        |=> (pend_ff && xfer_req);
  endproperty
  a_timer_sel: assert property (p_timer_sel) else $error("timer match did not raise request");

  property p_normal_odd_illegal;
    @(posedge mclk) disable iff (rst)
      (!block_mode && act_src_sel[0] && !act_src_sel[2]) |-> (cfg_illegal && !xfer_req);
  endproperty
  a_normal_odd_illegal: assert property (p_normal_odd_illegal) else $error("odd code accepted in normal mode");

  property p_ext_edge;
    @(posedge mclk) disable iff (rst)
      (chan_enable && act_src_sel == 3'h6 && ext_fall && !wr_ctrl) |=> pend_ff;
  endproperty
  a_ext_edge: assert property (p_ext_edge) else $error("falling edge did not latch request");

  property p_ext_level;
    @(posedge mclk) disable iff (rst)
      (chan_enable && !block_mode && act_src_sel == 3'h7) |-> (xfer_req == (ext_low || pend_ff));
  endproperty
  a_ext_level: assert property (p_ext_level) else $error("low level request mismatch");

  property p_level_block_illegal;
    @(posedge mclk) disable iff (rst)
      (block_mode && act_src_sel == 3'h7) |-> cfg_illegal;
  endproperty
  a_level_block_illegal: assert property (p_level_block_illegal) else $error("code 111 accepted in block mode");

  property p_block_side;
    @(posedge mclk) disable iff (rst)
      src_is_block == (block_mode && xfer_mode_sel);
  endproperty
  a_block_side: assert property (p_block_side) else $error("block area side wrong");

  property p_hold;
    @(posedge mclk) disable iff (rst)
      (xfer_done && !dest_step_enable && !wr_addr) |=> $stable(addr_ff);
  endproperty
  a_hold: assert property (p_hold) else $error("address moved with stepping off");

  property p_inc_word;
    @(posedge mclk) disable iff (rst)
      (xfer_done && dest_step_enable && !dest_step_direction && transfer_size_select && !wr_addr)
        |=> (addr_ff == AW'($past(addr_ff) + AW'(2)));
  endproperty
  a_inc_word: assert property (p_inc_word) else $error("word increment not two");

  property p_dec_byte;
    @(posedge mclk) disable iff (rst)
      (xfer_done && dest_step_enable && dest_step_direction && !transfer_size_select && !wr_addr)
        |=> (addr_ff == AW'($past(addr_ff) - AW'(1)));
  endproperty
  a_dec_byte: assert property (p_dec_byte) else $error("byte decrement not one");

  property p_dec_word;
    @(posedge mclk) disable iff (rst)
      (xfer_done && dest_step_enable && dest_step_direction && transfer_size_select && !wr_addr)
        |=> (addr_ff == AW'($past(addr_ff) - AW'(2)));
  endproperty
  a_dec_word: assert property (p_dec_word) else $error("word decrement not two");

  property p_cov_timer;
    @(posedge mclk) disable iff (rst)
      (block_mode && act_src_sel == 3'h3 && pend_set) ##[1:3] xfer_ack;
  endproperty
  c_cov_timer: cover property (p_cov_timer);

  property p_cov_edge;
    @(posedge mclk) disable iff (rst)
      (act_src_sel == 3'h6 && ext_fall && chan_enable);
  endproperty
  c_cov_edge: cover property (p_cov_edge);

  property p_cov_step;
    @(posedge mclk) disable iff (rst)
      (xfer_done && dest_step_enable) ##1 (xfer_done && dest_step_enable);
  endproperty
  c_cov_step: cover property (p_cov_step);

endmodule

// ### dmacb_far_model.sv
// far side model: timer channel match pulses and the external request pin
`timescale 1ns/1ps

module dmacb_far_model (
  input  wire logic       mclk,
  input  wire logic       rst,
  input  wire logic       fire,
  input  wire logic [1:0] fire_idx,
  input  wire logic       pin_low,
  output logic      [3:0] timer_match_a,
  output logic            ext_transfer_request_n
);
  logic [3:0] match_ff;
  logic [3:0] nxt_match;

  // one-cycle compare match pulse on the chosen timer channel only
  assign nxt_match = fire ? (4'h1 << fire_idx) : 4'h0;

  always_ff @(posedge mclk) begin
    if (rst) begin
      match_ff <= 4'h0;
    end else begin
      match_ff <= nxt_match;
    end
  end

  assign timer_match_a = match_ff;
  // pin has a pull-up: once released it reads high, never a stale low
  assign ext_transfer_request_n = ~pin_low;
endmodule

// ### dma_chan_b_activation_addr_step_bench.sv
// self-checking bench for the channel b activation and address step block
`timescale 1ns/1ps
`include "dmacb_defines.svh"

module dma_chan_b_activation_addr_step_bench;
  logic        mclk, rst, cyc, stb, we, fire, pin_low, xack, xdone;
  logic [7:0]  adr;
  logic [3:0]  sel;
  logic [1:0]  fidx;
  logic [31:0] wdat, q, dat_o;
  logic        ack, pin_n, req, burst, steal, sblk, ill;
  logic [3:0]  tmr;
  logic [23:0] daddr;
  int          n_errors, comparisons;

  dmacb_chan #(.AW(24)) dut_u (.mclk(mclk), .rst(rst), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
    .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(dat_o), .wb_ack_o(ack),
    .timer_match_a(tmr), .ext_transfer_request_n(pin_n), .xfer_ack(xack), .xfer_done(xdone),
    .xfer_req(req), .burst_mode(burst), .cycle_steal(steal), .src_is_block(sblk),
    .cfg_illegal(ill), .dest_address_reg(daddr));

  dmacb_far_model far_u (.mclk(mclk), .rst(rst), .fire(fire), .fire_idx(fidx), .pin_low(pin_low),
    .timer_match_a(tmr), .ext_transfer_request_n(pin_n));

  // ****************************************************************
  // bench tasks
  // ****************************************************************
  task automatic final_report;
    $display("comparisons %0d mismatches %0d", comparisons, n_errors);
    if (n_errors == 0 && comparisons > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      n_errors++;
      $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // one classic cycle; read data lands in q at the ack edge
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    wdat <= d;
    n = 0;
    do begin
      @(posedge mclk);
      n++;
    end while (ack !== 1'b1 && n < 20);
    q = dat_o;
    if (ack !== 1'b1) begin
      n_errors++;
      final_report();
    end
    cyc <= 1'b0;
    stb <= 1'b0;
    we <= 1'b0;
    @(posedge mclk);
  endtask

  task automatic wait_req(input logic e, input int lim);
    int n;
    n = 0;
    while (req !== e && n < lim) begin
      @(posedge mclk);
      n++;
    end
    chk(32'(req), 32'(e));
    if (req !== e) begin
      final_report();
    end
  endtask

  task automatic pulse_ack;
    xack <= 1'b1;
    @(posedge mclk);
    xack <= 1'b0;
  endtask

  function automatic logic [31:0] cw(input int c, t, se, sd, b, sz, en);
    return 32'(c + t * 8 + se * 16 + sd * 32 + b * 64 + sz * 128 + en * 256);
  endfunction

  task automatic step(input int se, sd, sz, input logic [23:0] a0, e);
    wb(1'b1, `DMACB_ADDR_OFS, {8'h00, a0});
    wb(1'b1, `DMACB_CTRL_OFS, cw(6, 0, se, sd, 0, sz, 0));
    xdone <= 1'b1;
    @(posedge mclk);
    xdone <= 1'b0;
    @(posedge mclk);
    chk({8'h00, daddr}, {8'h00, e});
    wb(1'b0, `DMACB_ADDR_OFS, 32'h0);
    chk(q, {8'h00, e});
  endtask

  // ****************************************************************
  // clock and main sequence
  // ****************************************************************
  initial begin
    mclk = 1'b0;
    forever #50 mclk = ~mclk;
  end

  initial begin
    {rst, cyc, stb, we, fire, pin_low, xack, xdone} = 8'hFF & 8'h80;
    adr = 8'h00;
    sel = 4'hF;
    fidx = 2'h0;
    wdat = 32'h0;
    n_errors = 0;
    comparisons = 0;
    repeat (20) @(posedge mclk);
    rst <= 1'b0;
    @(posedge mclk);
    wb(1'b0, `DMACB_CTRL_OFS, 32'h0);
    chk(q, 32'h0);
    chk(32'({burst, steal, sblk, ill, req}), 32'h10);
    wb(1'b0, 8'hFC, 32'h0);
    chk(q, 32'h0);
    $display("test reset ends");
    for (int b = 0; b < 2; b++) begin
      for (int c = 0; c < 8; c++) begin
        wb(1'b1, `DMACB_CTRL_OFS, cw(c, 0, 0, 0, b, 0, 1));
        chk(32'({burst, steal, ill, req}), 32'({b == 0 && c == 0, b == 0 && c == 2,
          b == 1 ? (c inside {4, 5, 7}) : (c inside {1, 3, 4, 5}), b == 0 && c inside {0, 2}}));
      end
    end
    $display("test code table ends");
    // a wrong channel first, so a decoder that ignores the code is caught
    for (int k = 0; k < 4; k++) begin
      wb(1'b1, `DMACB_CTRL_OFS, cw(k, 0, 0, 0, 1, 0, 1));
      fidx <= 2'(k + 1);
      fire <= 1'b1;
      @(posedge mclk);
      fire <= 1'b0;
      repeat (4) @(posedge mclk);
      chk(32'(req), 32'h0);
      fidx <= 2'(k);
      fire <= 1'b1;
      @(posedge mclk);
      fire <= 1'b0;
      wait_req(1'b1, 6);
      pulse_ack();
      wait_req(1'b0, 4);
    end
    $display("test timer sources ends");
    for (int b = 0; b < 2; b++) begin
      wb(1'b1, `DMACB_CTRL_OFS, cw(6, 0, 0, 0, b, 0, 1));
      pin_low <= 1'b1;
      wait_req(1'b1, 10);
      pulse_ack();
      repeat (6) @(posedge mclk);
      chk(32'(req), 32'h0);
      pin_low <= 1'b0;
      repeat (4) @(posedge mclk);
    end
    wb(1'b1, `DMACB_CTRL_OFS, cw(7, 0, 0, 0, 0, 0, 1));
    pin_low <= 1'b1;
    wait_req(1'b1, 10);
    wb(1'b0, `DMACB_STAT_OFS, 32'h0);
    chk(q, 32'h0000000A);
    pin_low <= 1'b0;
    wait_req(1'b0, 10);
    wb(1'b1, `DMACB_CTRL_OFS, cw(7, 0, 0, 0, 1, 0, 1));
    pin_low <= 1'b1;
    repeat (6) @(posedge mclk);
    chk(32'(req), 32'h0);
    pin_low <= 1'b0;
    $display("test request pin ends");
    for (int b = 0; b < 2; b++) begin
      for (int t = 0; t < 2; t++) begin
        wb(1'b1, `DMACB_CTRL_OFS, cw(0, t, 0, 0, b, 0, 0));
        chk(32'(sblk), 32'(b == 1 && t == 1));
      end
    end
    $display("test block side ends");
    step(0, 0, 0, 24'h000010, 24'h000010);
    step(0, 1, 1, 24'h000010, 24'h000010);
    step(1, 0, 0, 24'h000010, 24'h000011);
    step(1, 0, 1, 24'hFFFFFE, 24'h000000);
    step(1, 1, 0, 24'h000000, 24'hFFFFFF);
    step(1, 1, 1, 24'h000010, 24'h00000E);
    // only byte lane 0 enabled: upper address bytes must keep their value
    sel <= 4'h1;
    wb(1'b1, `DMACB_ADDR_OFS, 32'h00ABCD55);
    sel <= 4'hF;
    chk({8'h00, daddr}, 32'h00000055);
    $display("test address step ends");
    final_report();
  end
endmodule
